// *** hdl/rpc_pkg.sv ***
package rpc_pkg;

  // register indices; byte address is four times the index
  localparam logic [10:0] RPC_IX_LINE = 11'h00A;
  localparam logic [10:0] RPC_IX_SYS  = 11'h00B;
  localparam logic [10:0] RPC_IX_SYS0 = 11'h7CB;
  localparam logic [10:0] RPC_IX_GAIN = 11'h00C;
  localparam logic [10:0] RPC_IX_MODE = 11'h020;
  localparam logic [10:0] RPC_IX_STAT = 11'h021;

  // values after reset
  localparam logic [7:0] RPC_RST_LINE = 8'h47;
  localparam logic [7:0] RPC_RST_SYS  = 8'h01;
  localparam logic [7:0] RPC_RST_GAIN = 8'h00;
  localparam logic [7:0] RPC_RST_MODE = 8'h02;

  // writable bits of each register
  localparam logic [7:0] RPC_MSK_LINE = 8'hFF;
  localparam logic [7:0] RPC_MSK_SYS  = 8'h1F;
  localparam logic [7:0] RPC_MSK_GAIN = 8'h03;
  localparam logic [7:0] RPC_MSK_MODE = 8'h03;

  // line config field positions
  localparam int RPC_B_HOLD    = 7;
  localparam int RPC_B_FLOAT   = 6;
  localparam int RPC_B_PD      = 5;
  localparam int RPC_B_FULL    = 4;
  localparam int RPC_B_SINGLE  = 3;
  localparam int RPC_B_TERM_HI = 2;
  // system config field positions
  localparam int RPC_B_EDGE    = 4;
  localparam int RPC_B_INV     = 3;
  localparam int RPC_B_AMI     = 2;
  // mode and status field positions
  localparam int RPC_B_E1      = 0;
  localparam int RPC_B_PERCH   = 1;
  localparam int RPC_B_ST_LOS  = 0;
  localparam int RPC_B_ST_PD   = 1;

  // positions in the config word carried to the line domain
  localparam int RPC_C_AMI   = 2;
  localparam int RPC_C_INV   = 3;
  localparam int RPC_C_EDGE  = 4;
  localparam int RPC_C_HOLD  = 5;
  localparam int RPC_C_FLOAT = 6;
  localparam int RPC_C_PD    = 7;
  localparam int RPC_C_E1    = 8;

  // consecutive mark-free intervals before loss is declared
  localparam logic [6:0] RPC_LOS_LIMIT = 7'h20;

  // substitution clear masks, oldest interval in bit 7
  localparam logic [7:0] RPC_CLR_B8 = 8'h1B;
  localparam logic [7:0] RPC_CLR_HV = 8'h10;
  localparam logic [7:0] RPC_CLR_HB = 8'h90;

  typedef enum logic [1:0] {
    RPC_FMT_RSVD   = 2'b00,
    RPC_FMT_NRZ    = 2'b01,
    RPC_FMT_RZ     = 2'b10,
    RPC_FMT_SLICED = 2'b11
  } rpc_fmt_t;

  typedef enum logic [2:0] {
    RPC_SEL_NONE = 3'b000,
    RPC_SEL_LINE = 3'b001,
    RPC_SEL_SYS  = 3'b010,
    RPC_SEL_GAIN = 3'b011,
    RPC_SEL_MODE = 3'b100,
    RPC_SEL_STAT = 3'b101
  } rpc_sel_t;

endpackage : rpc_pkg

// *** hdl/rpc_receive_path_config.sv ***
// The APB register port was decided locally.
`timescale 1ns/1ps

// Operation
// - loss: clock follows reference, or held high
// - powered down: outputs low or floating
// - one bit powers receiver down
// - full internal match only differential, per-channel
// - one bit picks differential or single-ended
// - termination code picks internal ohms or external
// - single-ended forces external matching always
// - edge bit picks recovered clock active edge
// - invert bit makes data outputs active low
// - code bit picks B8ZS/HDB3 or AMI decoding
// - format 01 gives dual-rail NRZ output
// - format 10 gives dual-rail RZ output
// - format 11 gives raw sliced RZ output
// - gain field selects monitor gain step
// - config registers read-write, status read-only, reset 47H and 01H
// - one register per address, channel-zero alias
// - loss declared after run of empty intervals
module rpc_receive_path_config
  import rpc_pkg::*;
(
  // apb slave
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        clk_en,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [12:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // line side
  input  wire logic        line_clk,
  input  wire logic        line_input_tip,
  input  wire logic        line_input_ring,
  input  wire logic        reference_clock,
  input  wire logic        ais_pattern_active,
  // system side pins
  output logic             recovered_clock_out,
  output logic             recovered_clock_oe,
  output logic             receive_data_positive,
  output logic             receive_data_positive_oe,
  output logic             receive_data_negative,
  output logic             receive_data_negative_oe,
  output logic             line_signal_loss,
  // analog front-end control
  output logic             receiver_power_down,
  output logic             single_ended_input_sel,
  output logic             internal_match_en,
  output logic      [1:0]  match_impedance_sel,
  output logic             full_internal_match_sel,
  output logic      [1:0]  monitor_gain
);

  typedef struct packed {
    logic [7:0]  line;
    logic [7:0]  sys;
    logic [7:0]  gain;
    logic [7:0]  mode;
    logic        los_s1;
    logic        los_s2;
    logic [31:0] rdata;
    logic        err;
    logic        ok;
    logic        pd;
    logic        single;
    logic        int_en;
    logic [1:0]  ohm;
    logic        full;
    logic [1:0]  mg;
  } rpc_bus_t;

  typedef struct packed {
    logic       tip_s1;
    logic       tip_s2;
    logic       ring_s1;
    logic       ring_s2;
    logic       ais_s1;
    logic       ais_s2;
    logic [8:0] cfg_s1;
    logic [8:0] cfg_s2;
    logic [7:0] psr;
    logic [7:0] nsr;
    logic       last;
    logic [6:0] zc;
    logic       los;
    logic       dp;
    logic       dn;
  } rpc_link_t;

  rpc_bus_t   p_r;
  rpc_bus_t   p_nxt;
  rpc_link_t  l_r;
  rpc_link_t  l_nxt;
  rpc_sel_t   sel;
  logic       xfer;
  logic [8:0] cfg_src;
  logic [1:0] lrst_r;
  logic       lrst_n;
  logic [7:0] mk;
  logic [7:0] clr;
  logic [7:0] pp;
  logic [7:0] nn;
  logic       b8_hit;
  logic       hv_hit;
  logic       hb_hit;
  logic       mark_in;
  logic       gate;
  logic       pd_l;
  rpc_fmt_t   fmt_l;

  // address decode, shared by read, write and error answer
  function automatic rpc_sel_t rpc_decode(input logic [12:0] a);
    if (a[1:0] != 2'h0) begin
      return RPC_SEL_NONE;
    end
    case (a[12:2])
      RPC_IX_LINE: return RPC_SEL_LINE;
      RPC_IX_SYS:  return RPC_SEL_SYS;
      RPC_IX_SYS0: return RPC_SEL_SYS;
      RPC_IX_GAIN: return RPC_SEL_GAIN;
      RPC_IX_MODE: return RPC_SEL_MODE;
      RPC_IX_STAT: return RPC_SEL_STAT;
      default:     return RPC_SEL_NONE;
    endcase
  endfunction : rpc_decode

  // quasi-static settings handed to the line domain
  assign cfg_src = {p_r.mode[RPC_B_E1], p_r.line[RPC_B_PD], p_r.line[RPC_B_FLOAT],
                    p_r.line[RPC_B_HOLD], p_r.sys[RPC_B_EDGE], p_r.sys[RPC_B_INV],
                    p_r.sys[RPC_B_AMI], p_r.sys[1:0]};

  // bus handshake: ok marks read data latched for this transfer
  assign pready = clk_en & p_r.ok;
  assign xfer   = psel & penable & pready;

  // register file and bus answer
  always_comb begin
    sel    = rpc_decode(paddr);
    p_nxt  = p_r;
    p_nxt.los_s1 = l_r.los;
    p_nxt.los_s2 = p_r.los_s1;
    p_nxt.ok     = psel & ~xfer;
    // latch answer before the access edge so prdata comes from a flop
    if (psel & ~xfer) begin
      p_nxt.err = (sel == RPC_SEL_NONE);
      case (sel)
        RPC_SEL_LINE: p_nxt.rdata = {24'h000000, p_r.line};
        RPC_SEL_SYS:  p_nxt.rdata = {24'h000000, p_r.sys};
        RPC_SEL_GAIN: p_nxt.rdata = {24'h000000, p_r.gain};
        RPC_SEL_MODE: p_nxt.rdata = {24'h000000, p_r.mode};
        RPC_SEL_STAT: p_nxt.rdata = {30'h00000000, p_r.line[RPC_B_PD], p_r.los_s2};
        default:      p_nxt.rdata = 32'h00000000;
      endcase
    end else begin
      p_nxt.err = 1'b0;
    end
    // writes land at the access edge only; reserved bits masked off
    if (xfer & pwrite & pstrb[0] & ~p_r.err) begin
      case (sel)
        RPC_SEL_LINE: p_nxt.line = pwdata[7:0] & RPC_MSK_LINE;
        RPC_SEL_SYS:  p_nxt.sys  = pwdata[7:0] & RPC_MSK_SYS;
        RPC_SEL_GAIN: p_nxt.gain = pwdata[7:0] & RPC_MSK_GAIN;
        RPC_SEL_MODE: p_nxt.mode = pwdata[7:0] & RPC_MSK_MODE;
        default:      p_nxt.mode = p_r.mode;
      endcase
    end
    // front-end controls
    p_nxt.pd     = p_r.line[RPC_B_PD];
    p_nxt.single = p_r.line[RPC_B_SINGLE];
    // internal match only differential, per-channel, code 0XX
    p_nxt.int_en = ~p_r.line[RPC_B_SINGLE] & p_r.mode[RPC_B_PERCH]
                   & ~p_r.line[RPC_B_TERM_HI];
    p_nxt.ohm    = p_nxt.int_en ? p_r.line[1:0] : 2'h0;
    p_nxt.full   = p_nxt.int_en & p_r.line[RPC_B_FULL];
    p_nxt.mg     = p_r.gain[1:0];
  end

  // bus domain state, frozen while clk_en is low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      p_r      <= '0;
      p_r.line <= RPC_RST_LINE;
      p_r.sys  <= RPC_RST_SYS;
      p_r.gain <= RPC_RST_GAIN;
      p_r.mode <= RPC_RST_MODE;
      p_r.pd   <= 1'b0;
    end else if (clk_en) begin
      p_r <= p_nxt;
    end
  end

  // reset release synchronised to the line clock
  always_ff @(posedge line_clk or negedge presetn) begin
    if (!presetn) begin
      lrst_r <= 2'b00;
    end else begin
      lrst_r <= {lrst_r[0], 1'b1};
    end
  end
  assign lrst_n = lrst_r[1];

  // line domain: sync, decode, loss detection
  always_comb begin
    l_nxt = l_r;
    l_nxt.tip_s1  = line_input_tip;
    l_nxt.tip_s2  = l_r.tip_s1;
    l_nxt.ring_s1 = line_input_ring;
    l_nxt.ring_s2 = l_r.ring_s1;
    l_nxt.ais_s1  = ais_pattern_active;
    l_nxt.ais_s2  = l_r.ais_s1;
    l_nxt.cfg_s1  = cfg_src;
    l_nxt.cfg_s2  = l_r.cfg_s1;
    mk = l_r.psr | l_r.nsr;
    // B8ZS group 000VB0VB, oldest interval in bit 7
    b8_hit = ~l_r.cfg_s2[RPC_C_E1] & ~l_r.cfg_s2[RPC_C_AMI] & (mk[7:5] == 3'h0)
             & mk[4] & (l_r.psr[4] == l_r.last) & mk[3] & (l_r.psr[3] != l_r.psr[4])
             & ~mk[2] & mk[1] & (l_r.psr[1] == l_r.psr[3])
             & mk[0] & (l_r.psr[0] != l_r.psr[1]);
    // HDB3 groups 000V and B00V
    hv_hit = l_r.cfg_s2[RPC_C_E1] & ~l_r.cfg_s2[RPC_C_AMI] & (mk[7:5] == 3'h0)
             & mk[4] & (l_r.psr[4] == l_r.last);
    hb_hit = l_r.cfg_s2[RPC_C_E1] & ~l_r.cfg_s2[RPC_C_AMI] & mk[7] & (mk[6:5] == 2'h0)
             & mk[4] & (l_r.psr[4] == l_r.psr[7]) & (l_r.psr[7] != l_r.last);
    clr = 8'h00;
    if (b8_hit) begin
      clr = RPC_CLR_B8;
    end else if (hv_hit) begin
      clr = RPC_CLR_HV;
    end else if (hb_hit) begin
      clr = RPC_CLR_HB;
    end
    pp = l_r.psr & ~clr;
    nn = l_r.nsr & ~clr;
    // polarity memory; B00V flips it because the B obeyed alternation
    if (hb_hit) begin
      l_nxt.last = l_r.psr[7];
    end else if (pp[7] | nn[7]) begin
      l_nxt.last = pp[7];
    end
    l_nxt.psr = {pp[6:0], l_r.tip_s2};
    l_nxt.nsr = {nn[6:0], l_r.ring_s2};
    // sliced mode bypasses the decoder entirely
    if (rpc_fmt_t'(l_r.cfg_s2[1:0]) == RPC_FMT_SLICED) begin
      l_nxt.dp = l_r.tip_s2;
      l_nxt.dn = l_r.ring_s2;
    end else begin
      l_nxt.dp = pp[7];
      l_nxt.dn = nn[7];
    end
    // loss after a full run of intervals without any mark
    mark_in = l_r.tip_s2 | l_r.ring_s2;
    if (mark_in) begin
      l_nxt.zc = 7'h00;
    end else if (l_r.zc != RPC_LOS_LIMIT) begin
      l_nxt.zc = l_r.zc + 7'h01;
    end
    l_nxt.los = (l_nxt.zc == RPC_LOS_LIMIT);
  end

  // line domain state
  always_ff @(posedge line_clk or negedge lrst_n) begin
    if (!lrst_n) begin
      l_r <= '0;
    end else begin
      l_r <= l_nxt;
    end
  end

  // pin drive; RZ needs the clock phase since no faster clock exists
  assign pd_l  = l_r.cfg_s2[RPC_C_PD];
  assign fmt_l = rpc_fmt_t'(l_r.cfg_s2[1:0]);
  assign gate  = (fmt_l == RPC_FMT_RZ || fmt_l == RPC_FMT_SLICED) ? line_clk : 1'b1;
  assign receive_data_positive = pd_l ? 1'b0 : (l_r.cfg_s2[RPC_C_INV] ^ (l_r.dp & gate));
  assign receive_data_negative = pd_l ? 1'b0 : (l_r.cfg_s2[RPC_C_INV] ^ (l_r.dn & gate));
  // active edge placed mid-bit, data launches on line_clk rise
  assign recovered_clock_out = pd_l ? 1'b0 :
                               (l_r.los & ~l_r.ais_s2) ?
                               (l_r.cfg_s2[RPC_C_HOLD] ? 1'b1 : reference_clock) :
                               (l_r.cfg_s2[RPC_C_EDGE] ? line_clk : ~line_clk);
  assign recovered_clock_oe       = ~(pd_l & l_r.cfg_s2[RPC_C_FLOAT]);
  assign receive_data_positive_oe = ~(pd_l & l_r.cfg_s2[RPC_C_FLOAT]);
  assign receive_data_negative_oe = ~(pd_l & l_r.cfg_s2[RPC_C_FLOAT]);

  // registered outputs of the bus domain
  assign prdata                  = p_r.rdata;
  assign pslverr                 = p_r.err;
  assign line_signal_loss        = p_r.los_s2;
  assign receiver_power_down     = p_r.pd;
  assign single_ended_input_sel  = p_r.single;
  assign internal_match_en       = p_r.int_en;
  assign match_impedance_sel     = p_r.ohm;
  assign full_internal_match_sel = p_r.full;
  assign monitor_gain            = p_r.mg;

  // checks, bus domain
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_wr_line;
    xfer && pwrite && pstrb[0] && !p_r.err && sel == RPC_SEL_LINE;
  endsequence

  AST_RESET_VALUES: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(presetn) |-> p_r.line == RPC_RST_LINE && p_r.sys == RPC_RST_SYS)
    else $error("register reset value wrong");
  AST_WRITE_LINE: assert property (@(posedge pclk) disable iff (!presetn)
    s_setup ##1 s_wr_line |=> p_r.line == $past(pwdata[7:0]))
    else $error("line config write lost");
  AST_RESERVED_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
    p_r.sys[7:5] == 3'h0 && p_r.gain[7:2] == 6'h00)
    else $error("reserved bit set");
  AST_PD_FOLLOWS: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && p_r.line[RPC_B_PD] != receiver_power_down |=> receiver_power_down == $past(p_r.line[RPC_B_PD]))
    else $error("power down not applied");
  AST_SINGLE_EXT: assert property (@(posedge pclk) disable iff (!presetn)
    single_ended_input_sel |-> !internal_match_en && !full_internal_match_sel)
    else $error("internal match in single ended");
  AST_FULL_VALID: assert property (@(posedge pclk) disable iff (!presetn)
    full_internal_match_sel |-> !single_ended_input_sel && p_r.mode[RPC_B_PERCH])
    else $error("full internal match out of mode");

  // checks, line domain
  AST_LOS_DECLARE: assert property (@(posedge line_clk) disable iff (!lrst_n)
    l_r.zc == RPC_LOS_LIMIT - 7'h01 && !mark_in |=> l_r.los)
    else $error("loss not declared");
  AST_LOS_CLEAR: assert property (@(posedge line_clk) disable iff (!lrst_n)
    mark_in |=> !l_r.los ##1 $stable(l_r.zc) || l_r.zc <= 7'h01)
    else $error("loss not cleared by mark");
  AST_B8ZS_ZERO: assert property (@(posedge line_clk) disable iff (!lrst_n)
    b8_hit && fmt_l != RPC_FMT_SLICED |=> (!l_r.dp && !l_r.dn) [*8])
    else $error("b8zs group not removed");
  AST_HDB3_ZERO: assert property (@(posedge line_clk) disable iff (!lrst_n)
    hv_hit && fmt_l != RPC_FMT_SLICED |=> (!l_r.dp && !l_r.dn) [*4])
    else $error("hdb3 group not removed");
  AST_CLK_HOLD: assert property (@(posedge line_clk) disable iff (!lrst_n)
    l_r.los && !l_r.ais_s2 && l_r.cfg_s2[RPC_C_HOLD] && !pd_l |-> recovered_clock_out)
    else $error("clock not held high on loss");
  AST_PD_LOW: assert property (@(posedge line_clk) disable iff (!lrst_n)
    pd_l && !l_r.cfg_s2[RPC_C_FLOAT] |-> recovered_clock_oe && !recovered_clock_out
    && !receive_data_positive && !receive_data_negative)
    else $error("powered down outputs not low");
  AST_PD_FLOAT: assert property (@(posedge line_clk) disable iff (!lrst_n)
    pd_l && l_r.cfg_s2[RPC_C_FLOAT] |-> !recovered_clock_oe && !receive_data_positive_oe)
    else $error("powered down outputs driven");

endmodule : rpc_receive_path_config

// *** tb/rpc_line_src.sv ***
`timescale 1ns/1ps

// line-side source: one sliced mark per interval on the selected rail
module rpc_line_src (
  // link
  input  wire logic line_clk,
  // control from the bench
  input  wire logic mark_en,
  input  wire logic use_ring,
  // sliced marks toward the receiver
  output logic      line_input_tip,
  output logic      line_input_ring
);
  initial begin
    line_input_tip  = 1'b0;
    line_input_ring = 1'b0;
  end

  // marks change just after the rise; mark_en low starves the loss detector
  always @(posedge line_clk) begin
    line_input_tip  <= mark_en & ~use_ring;
    line_input_ring <= mark_en & use_ring;
  end
endmodule : rpc_line_src

// *** tb/tb_top.sv ***
`timescale 1ns/1ps

`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin error_cnt++; \
  $display("wrong value %s exp %0h seen %0h", nm, ex, got); end end

module tb_top;
  import rpc_pkg::*;
  localparam logic [12:0] A_LINE = {RPC_IX_LINE, 2'b00};
  localparam logic [12:0] A_SYS  = {RPC_IX_SYS, 2'b00};
  localparam logic [12:0] A_SYS0 = {RPC_IX_SYS0, 2'b00};
  localparam logic [12:0] A_GAIN = {RPC_IX_GAIN, 2'b00};
  localparam logic [12:0] A_MODE = {RPC_IX_MODE, 2'b00};
  localparam logic [12:0] A_STAT = {RPC_IX_STAT, 2'b00};
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, line_clk, ref_clk, mark_en, use_ring, ais;
  logic [12:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0]  pstrb;
  logic tip, ring, rck, rck_oe, rdp, rdp_oe, rdn, rdn_oe, los, pd, sing, int_en, full;
  logic [1:0]  imp, gain;
  int error_cnt = 0;
  int cmp_count = 0;

  rpc_receive_path_config dut (.pclk(pclk), .presetn(presetn), .clk_en(1'b1), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .line_clk(line_clk), .line_input_tip(tip), .line_input_ring(ring),
    .reference_clock(ref_clk), .ais_pattern_active(ais), .recovered_clock_out(rck),
    .recovered_clock_oe(rck_oe), .receive_data_positive(rdp), .receive_data_positive_oe(rdp_oe),
    .receive_data_negative(rdn), .receive_data_negative_oe(rdn_oe), .line_signal_loss(los),
    .receiver_power_down(pd), .single_ended_input_sel(sing), .internal_match_en(int_en),
    .match_impedance_sel(imp), .full_internal_match_sel(full), .monitor_gain(gain));

  rpc_line_src src (.line_clk(line_clk), .mark_en(mark_en), .use_ring(use_ring),
    .line_input_tip(tip), .line_input_ring(ring));

  // bus clock 5 ns, link clock 160 ns with an unrelated phase
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  initial begin
    line_clk = 1'b0;
    #37.3;
    forever #80 line_clk = ~line_clk;
  end

  // one apb transfer; pready, prdata and pslverr sampled at the same rising edge
  task automatic xfer(input logic w, input logic [12:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic er);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 100);
    if (n >= 100) begin
      error_cnt++;
    end
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : xfer

  task automatic wr(input logic [12:0] a, input logic [7:0] d);
    logic [31:0] r;
    logic e;
    xfer(1'b1, a, {24'h000000, d}, r, e);
    repeat (3) @(posedge pclk);
  endtask : wr

  task automatic rchk(input logic [12:0] a, input logic [7:0] ex, input logic ex_err);
    logic [31:0] r;
    logic e;
    xfer(1'b0, a, 32'h00000000, r, e);
    `CHK("prdata", {24'h000000, ex}, r)
    `CHK("pslverr", ex_err, e)
  endtask : rchk

  // let the config cross into the line domain and the pipe refill
  task automatic lwait(input int n);
    repeat (n) @(posedge line_clk);
    #3;
  endtask : lwait

  task automatic results();
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : results

  initial begin
    #400000;
    error_cnt++;
    results();
  end

  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 13'h0000;
    pwdata = 32'h00000000; pstrb = 4'hF; ref_clk = 1'b0; mark_en = 1'b1; use_ring = 1'b0; ais = 1'b0;
    repeat (10) @(posedge pclk);
    repeat (3) @(posedge line_clk); // line domain needs a few link edges in reset too
    @(posedge pclk);
    presetn <= 1'b1;
    // reset values, reserved bits, alias and unmapped places
    rchk(A_LINE, 8'h47, 1'b0);
    rchk(A_SYS, 8'h01, 1'b0);
    rchk(A_GAIN, 8'h00, 1'b0);
    `CHK("int_en", 1'b0, int_en)
    wr(A_SYS, 8'hFF);
    rchk(A_SYS, 8'h1F, 1'b0);
    wr(A_SYS0, 8'h0A);
    rchk(A_SYS, 8'h0A, 1'b0);
    rchk(13'h0100, 8'h00, 1'b1);
    rchk(13'h0029, 8'h00, 1'b1);
    for (int g = 0; g < 4; g++) begin
      wr(A_GAIN, 8'hFC | 8'(g));
      rchk(A_GAIN, 8'(g), 1'b0);
      `CHK("gain", 2'(g), gain)
    end
    // termination codes with per-channel matching on in differential mode
    for (int c = 0; c < 4; c++) begin
      wr(A_LINE, 8'h40 | 8'(c));
      `CHK("int_en", 1'b1, int_en)
      `CHK("imp", 2'(c), imp)
    end
    wr(A_LINE, 8'h52);
    `CHK("full", 1'b1, full)
    wr(A_LINE, 8'h4A);
    `CHK("single", 1'b1, sing)
    `CHK("int_en", 1'b0, int_en)
    wr(A_LINE, 8'h47);
    `CHK("single", 1'b0, sing)
    // data formats with marks on one rail, AMI so nothing is substituted
    wr(A_SYS, 8'h05);
    lwait(20);
    `CHK("rdp nrz", 1'b1, rdp)
    `CHK("rdn nrz", 1'b0, rdn)
    `CHK("clk rise", ~line_clk, rck)
    @(negedge line_clk);
    #3;
    `CHK("rdp nrz low", 1'b1, rdp)
    use_ring = 1'b1;
    lwait(20);
    `CHK("rdn nrz", 1'b1, rdn)
    `CHK("rdp nrz", 1'b0, rdp)
    use_ring = 1'b0;
    wr(A_SYS, 8'h0D);
    lwait(20);
    `CHK("rdp inv", 1'b0, rdp)
    wr(A_SYS, 8'h16);
    lwait(20);
    `CHK("rdp rz hi", 1'b1, rdp)
    `CHK("clk fall", line_clk, rck)
    @(negedge line_clk);
    #3;
    `CHK("rdp rz lo", 1'b0, rdp)
    wr(A_SYS, 8'h07);
    lwait(20);
    `CHK("rdp sl hi", 1'b1, rdp)
    @(negedge line_clk);
    #3;
    `CHK("rdp sl lo", 1'b0, rdp)
    wr(A_SYS, 8'h01);
    // power down, floating then driven low
    wr(A_LINE, 8'h67);
    lwait(6);
    `CHK("pd", 1'b1, pd)
    `CHK("oe", 3'b000, {rck_oe, rdp_oe, rdn_oe})
    wr(A_LINE, 8'h27);
    lwait(6);
    `CHK("oe", 3'b111, {rck_oe, rdp_oe, rdn_oe})
    `CHK("pins", 3'b000, {rck, rdp, rdn})
    wr(A_LINE, 8'h47);
    lwait(20);
    `CHK("pd", 1'b0, pd)
    // loss: starve the line, then the clock follows reference or holds high
    mark_en = 1'b0;
    lwait(50);
    `CHK("loss", 1'b1, los)
    rchk(A_STAT, 8'h01, 1'b0);
    ref_clk = 1'b1;
    #2;
    `CHK("rck ref1", 1'b1, rck)
    ref_clk = 1'b0;
    #2;
    `CHK("rck ref0", 1'b0, rck)
    wr(A_LINE, 8'hC7);
    lwait(6);
    `CHK("rck hold", 1'b1, rck)
    // alarm pattern active: loss no longer overrides the recovered clock
    ais = 1'b1;
    lwait(4);
    `CHK("rck ais", ~line_clk, rck)
    ais = 1'b0;
    lwait(4);
    `CHK("rck hold2", 1'b1, rck)
    mark_en = 1'b1;
    lwait(10);
    `CHK("loss clr", 1'b0, los)
    results();
  end
endmodule : tb_top
